// ### core/dccr_top.sv
/*
 * Control and status registers for two on-chip voltage comparators:
 * control, mode and input select registers in the special function
 * register space, plus the settings handed to the analog cores.
 * Assumes a single-cycle register port on ref_clk_in and analog cores
 * that consume the static settings and return a raw output level.
 */
module dccr_top (
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          sys_rst_in,
    // Special function register port
    input  wire logic [dccr_pkg::ADDR_W-1:0]   sfr_addr_in,
    input  wire logic                          sfr_wr_en_in,
    input  wire logic [dccr_pkg::DATA_W-1:0]   sfr_wdata_in,
    input  wire logic                          sfr_rd_en_in,
    output logic      [dccr_pkg::DATA_W-1:0]   sfr_rdata_out,
    // Raw analog comparator outputs
    input  wire logic                          cmp_a_raw_in,
    input  wire logic                          cmp_b_raw_in,
    // Comparator A analog settings
    output logic                               cmp_a_enable_out,
    output logic      [dccr_pkg::SPEED_W-1:0]  cmp_a_speed_mode_out,
    output logic      [dccr_pkg::HYST_W-1:0]   cmp_a_pos_hyst_sel_out,
    output logic      [dccr_pkg::HYST_W-1:0]   cmp_a_neg_hyst_sel_out,
    output logic      [dccr_pkg::MUX_SEL_W-1:0] cmp_a_pos_input_sel_out,
    output logic      [dccr_pkg::MUX_SEL_W-1:0] cmp_a_neg_input_sel_out,
    // Comparator B analog settings
    output logic                               cmp_b_enable_out,
    output logic      [dccr_pkg::SPEED_W-1:0]  cmp_b_speed_mode_out,
    output logic      [dccr_pkg::HYST_W-1:0]   cmp_b_pos_hyst_sel_out,
    output logic      [dccr_pkg::HYST_W-1:0]   cmp_b_neg_hyst_sel_out,
    output logic      [dccr_pkg::MUX_SEL_W-1:0] cmp_b_pos_input_sel_out,
    output logic      [dccr_pkg::MUX_SEL_W-1:0] cmp_b_neg_input_sel_out,
    // Synchronous outputs toward the port crossbar
    output logic                               cmp_a_pin_out,
    output logic                               cmp_b_pin_out,
    // Interrupt requests
    output logic                               cmp_a_irq_out,
    output logic                               cmp_b_irq_out
);
    import dccr_pkg::*;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire sel_a_ctl = (sfr_addr_in == ADDR_CMP_A_CONTROL);
    wire sel_a_md  = (sfr_addr_in == ADDR_CMP_A_MODE);
    wire sel_a_mx  = (sfr_addr_in == ADDR_CMP_A_INPUT_SELECT);
    wire sel_b_ctl = (sfr_addr_in == ADDR_CMP_B_CONTROL);
    wire sel_b_md  = (sfr_addr_in == ADDR_CMP_B_MODE);
    wire sel_b_mx  = (sfr_addr_in == ADDR_CMP_B_INPUT_SELECT);

    wire wr_a_ctl  = sfr_wr_en_in & sel_a_ctl;
    wire wr_a_md   = sfr_wr_en_in & sel_a_md;
    wire wr_a_mx   = sfr_wr_en_in & sel_a_mx;
    wire wr_b_ctl  = sfr_wr_en_in & sel_b_ctl;
    wire wr_b_md   = sfr_wr_en_in & sel_b_md;
    wire wr_b_mx   = sfr_wr_en_in & sel_b_mx;

    // ************************************************************
    // Write data fields
    // ************************************************************
    // Control bit 6 has no field here, so writes never reach the output state.
    wire                 wd_en  = sfr_wdata_in[CTL_ENABLE_BIT];
    wire                 wd_rif = sfr_wdata_in[CTL_RISE_BIT];
    wire                 wd_fif = sfr_wdata_in[CTL_FALL_BIT];
    wire [HYST_W-1:0]    wd_hyp = sfr_wdata_in[CTL_HYP_LSB +: HYST_W];
    wire [HYST_W-1:0]    wd_hyn = sfr_wdata_in[CTL_HYN_LSB +: HYST_W];
    wire                 wd_rie = sfr_wdata_in[MODE_RISE_IE_BIT];
    wire                 wd_fie = sfr_wdata_in[MODE_FALL_IE_BIT];
    wire [SPEED_W-1:0]   wd_md  = sfr_wdata_in[MODE_SPEED_LSB +: SPEED_W];
    wire [MUX_SEL_W-1:0] wd_mxp = sfr_wdata_in[MUX_POS_LSB +: MUX_SEL_W];
    wire [MUX_SEL_W-1:0] wd_mxn = sfr_wdata_in[MUX_NEG_LSB +: MUX_SEL_W];

    // ************************************************************
    // Comparator A stored fields
    // ************************************************************
    logic                 a_en_q;
    logic [HYST_W-1:0]    a_hyp_q;
    logic [HYST_W-1:0]    a_hyn_q;
    logic                 a_rie_q;
    logic                 a_fie_q;
    logic [SPEED_W-1:0]   a_md_q;
    logic [MUX_SEL_W-1:0] a_mxp_q;
    logic [MUX_SEL_W-1:0] a_mxn_q;

    // ************************************************************
    // Comparator A next values
    // ************************************************************
    // Each field keeps its value unless its own register is written.
    wire                 a_en_d  = wr_a_ctl ? wd_en  : a_en_q;
    wire [HYST_W-1:0]    a_hyp_d = wr_a_ctl ? wd_hyp : a_hyp_q;
    wire [HYST_W-1:0]    a_hyn_d = wr_a_ctl ? wd_hyn : a_hyn_q;
    wire                 a_rie_d = wr_a_md  ? wd_rie : a_rie_q;
    wire                 a_fie_d = wr_a_md  ? wd_fie : a_fie_q;
    wire [SPEED_W-1:0]   a_md_d  = wr_a_md  ? wd_md  : a_md_q;
    wire [MUX_SEL_W-1:0] a_mxp_d = wr_a_mx  ? wd_mxp : a_mxp_q;
    wire [MUX_SEL_W-1:0] a_mxn_d = wr_a_mx  ? wd_mxn : a_mxn_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            a_en_q  <= 1'b0;
            a_hyp_q <= RST_HYST;
            a_hyn_q <= RST_HYST;
        end else begin
            a_en_q  <= a_en_d;
            a_hyp_q <= a_hyp_d;
            a_hyn_q <= a_hyn_d;
        end
    end

    // Unused mode bits are simply not stored, so writes to them vanish.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            a_rie_q <= 1'b0;
            a_fie_q <= 1'b0;
            a_md_q  <= RST_SPEED_MODE;
        end else begin
            a_rie_q <= a_rie_d;
            a_fie_q <= a_fie_d;
            a_md_q  <= a_md_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            a_mxp_q <= RST_MUX_POS;
            a_mxn_q <= RST_MUX_NEG;
        end else begin
            a_mxp_q <= a_mxp_d;
            a_mxn_q <= a_mxn_d;
        end
    end

    // ************************************************************
    // Comparator B stored fields
    // ************************************************************
    logic                 b_en_q;
    logic [HYST_W-1:0]    b_hyp_q;
    logic [HYST_W-1:0]    b_hyn_q;
    logic                 b_rie_q;
    logic                 b_fie_q;
    logic [SPEED_W-1:0]   b_md_q;
    logic [MUX_SEL_W-1:0] b_mxp_q;
    logic [MUX_SEL_W-1:0] b_mxn_q;

    // ************************************************************
    // Comparator B next values
    // ************************************************************
    // The same hold-unless-written pattern as comparator A.
    wire                 b_en_d  = wr_b_ctl ? wd_en  : b_en_q;
    wire [HYST_W-1:0]    b_hyp_d = wr_b_ctl ? wd_hyp : b_hyp_q;
    wire [HYST_W-1:0]    b_hyn_d = wr_b_ctl ? wd_hyn : b_hyn_q;
    wire                 b_rie_d = wr_b_md  ? wd_rie : b_rie_q;
    wire                 b_fie_d = wr_b_md  ? wd_fie : b_fie_q;
    wire [SPEED_W-1:0]   b_md_d  = wr_b_md  ? wd_md  : b_md_q;
    wire [MUX_SEL_W-1:0] b_mxp_d = wr_b_mx  ? wd_mxp : b_mxp_q;
    wire [MUX_SEL_W-1:0] b_mxn_d = wr_b_mx  ? wd_mxn : b_mxn_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            b_en_q  <= 1'b0;
            b_hyp_q <= RST_HYST;
            b_hyn_q <= RST_HYST;
        end else begin
            b_en_q  <= b_en_d;
            b_hyp_q <= b_hyp_d;
            b_hyn_q <= b_hyn_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            b_rie_q <= 1'b0;
            b_fie_q <= 1'b0;
            b_md_q  <= RST_SPEED_MODE;
        end else begin
            b_rie_q <= b_rie_d;
            b_fie_q <= b_fie_d;
            b_md_q  <= b_md_d;
        end
    end

    // Each multiplexer has its own select, so both may name one pin.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            b_mxp_q <= RST_MUX_POS;
            b_mxn_q <= RST_MUX_NEG;
        end else begin
            b_mxp_q <= b_mxp_d;
            b_mxn_q <= b_mxn_d;
        end
    end

    // ************************************************************
    // Status channels
    // ************************************************************
    logic a_out;
    logic a_rif;
    logic a_fif;
    logic b_out;
    logic b_rif;
    logic b_fif;

    // The flags live in the channel; a control write updates them too.
    dccr_edge_channel u_chan_a (
        .ref_clk_in     (ref_clk_in),
        .sys_rst_in     (sys_rst_in),
        .cmp_raw_in     (cmp_a_raw_in),
        .enable_in      (a_en_q),
        .rise_irq_en_in (a_rie_q),
        .fall_irq_en_in (a_fie_q),
        .flag_wr_in     (wr_a_ctl),
        .rise_wdata_in  (wd_rif),
        .fall_wdata_in  (wd_fif),
        .out_state_out  (a_out),
        .rise_flag_out  (a_rif),
        .fall_flag_out  (a_fif),
        .irq_out        (cmp_a_irq_out)
    );

    dccr_edge_channel u_chan_b (
        .ref_clk_in     (ref_clk_in),
        .sys_rst_in     (sys_rst_in),
        .cmp_raw_in     (cmp_b_raw_in),
        .enable_in      (b_en_q),
        .rise_irq_en_in (b_rie_q),
        .fall_irq_en_in (b_fie_q),
        .flag_wr_in     (wr_b_ctl),
        .rise_wdata_in  (wd_rif),
        .fall_wdata_in  (wd_fif),
        .out_state_out  (b_out),
        .rise_flag_out  (b_rif),
        .fall_flag_out  (b_fif),
        .irq_out        (cmp_b_irq_out)
    );

    // ************************************************************
    // Read-back
    // ************************************************************
    wire [7:0] a_ctl_rd = {a_en_q, a_out, a_rif, a_fif, a_hyp_q, a_hyn_q};
    wire [7:0] b_ctl_rd = {b_en_q, b_out, b_rif, b_fif, b_hyp_q, b_hyn_q};
    wire [7:0] a_md_rd  = {2'h0, a_rie_q, a_fie_q, 2'h0, a_md_q};
    wire [7:0] b_md_rd  = {2'h0, b_rie_q, b_fie_q, 2'h0, b_md_q};
    wire [7:0] a_mx_rd  = {a_mxn_q, a_mxp_q};
    wire [7:0] b_mx_rd  = {b_mxn_q, b_mxp_q};

    // Unmapped addresses read as zero.
    wire [7:0] rd_mux   = ({8{sel_a_ctl}} & a_ctl_rd)
                        | ({8{sel_a_md}}  & a_md_rd)
                        | ({8{sel_a_mx}}  & a_mx_rd)
                        | ({8{sel_b_ctl}} & b_ctl_rd)
                        | ({8{sel_b_md}}  & b_md_rd)
                        | ({8{sel_b_mx}}  & b_mx_rd);

    logic [7:0] rdata_q;

    // A read beside a write to the same register returns the old contents.
    wire  [7:0] rdata_d = sfr_rd_en_in ? rd_mux : rdata_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= RST_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_out = rdata_q;

    // ************************************************************
    // Settings to the analog cores and crossbar
    // ************************************************************
    assign cmp_a_enable_out        = a_en_q;
    assign cmp_a_speed_mode_out    = a_md_q;
    assign cmp_a_pos_hyst_sel_out  = a_hyp_q;
    assign cmp_a_neg_hyst_sel_out  = a_hyn_q;
    assign cmp_a_pos_input_sel_out = a_mxp_q;
    assign cmp_a_neg_input_sel_out = a_mxn_q;
    assign cmp_b_enable_out        = b_en_q;
    assign cmp_b_speed_mode_out    = b_md_q;
    assign cmp_b_pos_hyst_sel_out  = b_hyp_q;
    assign cmp_b_neg_hyst_sel_out  = b_hyn_q;
    assign cmp_b_pos_input_sel_out = b_mxp_q;
    assign cmp_b_neg_input_sel_out = b_mxn_q;

    // Pin outputs are already gated low while disabled.
    assign cmp_a_pin_out           = a_out;
    assign cmp_b_pin_out           = b_out;

endmodule : dccr_top

// ### core/dccr_pkg.sv
/*
 * Shared constants for the dual comparator control and status logic:
 * special function register addresses, field positions and reset values.
 * Assumes an 8-bit special function register space with 8-bit data.
 */
package dccr_pkg;

    // ************************************************************
    // Register space geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CMP = 2;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CMP_A_CONTROL      = 8'h9a;
    localparam logic [7:0] ADDR_CMP_A_MODE         = 8'h9b;
    localparam logic [7:0] ADDR_CMP_A_INPUT_SELECT = 8'h9c;
    localparam logic [7:0] ADDR_CMP_B_CONTROL      = 8'h9d;
    localparam logic [7:0] ADDR_CMP_B_MODE         = 8'h9e;
    localparam logic [7:0] ADDR_CMP_B_INPUT_SELECT = 8'h9f;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int unsigned CTL_ENABLE_BIT   = 7;
    localparam int unsigned CTL_OUT_BIT      = 6;
    localparam int unsigned CTL_RISE_BIT     = 5;
    localparam int unsigned CTL_FALL_BIT     = 4;
    localparam int unsigned CTL_HYP_LSB      = 2;
    localparam int unsigned CTL_HYN_LSB      = 0;
    localparam int unsigned HYST_W           = 2;

    // ************************************************************
    // Mode register fields
    // ************************************************************
    localparam int unsigned MODE_RISE_IE_BIT = 5;
    localparam int unsigned MODE_FALL_IE_BIT = 4;
    localparam int unsigned MODE_SPEED_LSB   = 0;
    localparam int unsigned SPEED_W          = 2;

    // ************************************************************
    // Input select register fields
    // ************************************************************
    localparam int unsigned MUX_NEG_LSB      = 4;
    localparam int unsigned MUX_POS_LSB      = 0;
    localparam int unsigned MUX_SEL_W        = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] RST_SPEED_MODE    = 2'h2;
    localparam logic [1:0] RST_HYST          = 2'h0;
    localparam logic [3:0] RST_MUX_NEG       = 4'h7;
    localparam logic [3:0] RST_MUX_POS       = 4'h7;
    localparam logic [7:0] RST_RDATA         = 8'h00;

endpackage : dccr_pkg

// ### core/dccr_edge_channel.sv
/*
 * One comparator's digital status path: synchroniser, enable gating,
 * sticky rising and falling edge flags and the combined interrupt request.
 * Assumes the raw comparator output is asynchronous to ref_clk_in.
 */
module dccr_edge_channel (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    // Analog core output
    input  wire logic cmp_raw_in,
    // Configuration
    input  wire logic enable_in,
    input  wire logic rise_irq_en_in,
    input  wire logic fall_irq_en_in,
    // Software access to the flags
    input  wire logic flag_wr_in,
    input  wire logic rise_wdata_in,
    input  wire logic fall_wdata_in,
    // Status
    output logic      out_state_out,
    output logic      rise_flag_out,
    output logic      fall_flag_out,
    output logic      irq_out
);
    import dccr_pkg::*;

    // ************************************************************
    // Synchroniser and edge detection
    // ************************************************************
    logic meta_q;
    logic sync_q;
    logic state_q;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;
    logic irq_q;

    // A disabled comparator reads and drives low.
    wire  state_d   = enable_in & sync_q;
    wire  rise_edge = state_d & ~state_q;
    wire  fall_edge = ~state_d & state_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q  <= 1'b0;
            sync_q  <= 1'b0;
            state_q <= 1'b0;
        end else begin
            meta_q  <= cmp_raw_in;
            sync_q  <= meta_q;
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************
    // An edge in the same cycle as a software clear keeps the flag set.
    assign rise_d = rise_edge | (flag_wr_in ? rise_wdata_in : rise_q);
    assign fall_d = fall_edge | (flag_wr_in ? fall_wdata_in : fall_q);

    wire irq_d = (rise_d & rise_irq_en_in) | (fall_d & fall_irq_en_in);

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            rise_q <= rise_d;
            fall_q <= fall_d;
            irq_q  <= irq_d;
        end
    end

    assign out_state_out = state_q;
    assign rise_flag_out = rise_q;
    assign fall_flag_out = fall_q;
    assign irq_out       = irq_q;

endmodule : dccr_edge_channel

// ### testbench/dccr_checker.sv
/* Concurrent checks on the comparator register block ports.
   Assumes one clock domain with the asynchronous active high reset. */
module dccr_checker (
    // Clock, reset and register port
    input wire logic                            ref_clk_in,
    input wire logic                            sys_rst_in,
    input wire logic [dccr_pkg::ADDR_W-1:0]     sfr_addr_in,
    input wire logic                            sfr_wr_en_in,
    input wire logic [dccr_pkg::DATA_W-1:0]     sfr_wdata_in,
    input wire logic                            sfr_rd_en_in,
    input wire logic [dccr_pkg::DATA_W-1:0]     sfr_rdata_out,
    // Comparator status and settings
    input wire logic                            cmp_b_raw_in,
    input wire logic                            cmp_b_enable_out,
    input wire logic [dccr_pkg::SPEED_W-1:0]    cmp_b_speed_mode_out,
    input wire logic [dccr_pkg::HYST_W-1:0]     cmp_b_pos_hyst_sel_out,
    input wire logic [dccr_pkg::HYST_W-1:0]     cmp_b_neg_hyst_sel_out,
    input wire logic [dccr_pkg::MUX_SEL_W-1:0]  cmp_a_pos_input_sel_out,
    input wire logic [dccr_pkg::MUX_SEL_W-1:0]  cmp_a_neg_input_sel_out,
    input wire logic                            cmp_b_pin_out,
    input wire logic                            cmp_b_irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import dccr_pkg::*;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_wr(logic [7:0] a);
        sfr_wr_en_in && sfr_addr_in == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        sfr_rd_en_in && sfr_addr_in == a;
    endsequence

    property p_mode_zero;
        s_rd(ADDR_CMP_B_MODE) |=> sfr_rdata_out[7:6] == 2'h0 && sfr_rdata_out[3:2] == 2'h0;
    endproperty
    a_mode_zero: assert property (p_mode_zero) else $error("mode spare bits");
    property p_speed;
        s_wr(ADDR_CMP_B_MODE) |=> cmp_b_speed_mode_out == $past(sfr_wdata_in[1:0]);
    endproperty
    a_speed: assert property (p_speed) else $error("speed mode");
    property p_hyst;
        s_wr(ADDR_CMP_B_CONTROL) |=> {cmp_b_pos_hyst_sel_out, cmp_b_neg_hyst_sel_out}
            == $past(sfr_wdata_in[3:0]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis");
    property p_enable;
        s_wr(ADDR_CMP_B_CONTROL) |=> cmp_b_enable_out == $past(sfr_wdata_in[7]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable");
    property p_mux;
        s_wr(ADDR_CMP_A_INPUT_SELECT) |=>
            {cmp_a_neg_input_sel_out, cmp_a_pos_input_sel_out} == $past(sfr_wdata_in);
    endproperty
    a_mux: assert property (p_mux) else $error("input select");
    property p_mux_indep;
        s_wr(ADDR_CMP_B_INPUT_SELECT) |=> $stable(cmp_a_pos_input_sel_out)
            && $stable(cmp_a_neg_input_sel_out);
    endproperty
    a_mux_indep: assert property (p_mux_indep) else $error("select crosstalk");
    property p_pin_off;
        (!cmp_b_enable_out)[*3] |-> !cmp_b_pin_out;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin while disabled");
    property p_pin_on;
        (cmp_b_enable_out && cmp_b_raw_in)[*5] |-> cmp_b_pin_out;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("pin follow");
    property p_irq_fall;
        $fell(cmp_b_irq_out) |-> $past(sfr_wr_en_in && sfr_addr_in == ADDR_CMP_B_CONTROL)
            || $past(sfr_wr_en_in && sfr_addr_in == ADDR_CMP_B_MODE, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
endmodule : dccr_checker

bind dccr_top dccr_checker dccr_checker_inst (.*);

// ### testbench/tb_dccr_top.sv
/* Self-checking bench for the comparator register block with a register model.
   Assumes the registered read port and two-flop input synchroniser of the core. */
module tb_dccr_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dccr_pkg::*;

    logic        ref_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  sfr_addr_in = 8'h00;
    logic [7:0]  sfr_wdata_in = 8'h00;
    logic        sfr_wr_en_in = 1'b0;
    logic        sfr_rd_en_in = 1'b0;
    logic [1:0]  raw = 2'h0;
    wire  [7:0]  sfr_rdata_out;
    wire  [1:0][16:0] obs;
    logic [7:0]  ctl [2] = '{8'h00, 8'h00};
    logic [7:0]  mode [2] = '{8'h02, 8'h02};
    logic [7:0]  sel [2] = '{8'h77, 8'h77};
    logic [31:0] rng = 32'h64e6d067;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    dccr_top dccr_top_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_en_in(sfr_wr_en_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rd_en_in(sfr_rd_en_in), .sfr_rdata_out(sfr_rdata_out),
        .cmp_a_raw_in(raw[0]), .cmp_b_raw_in(raw[1]),
        .cmp_a_enable_out(obs[0][16]), .cmp_a_speed_mode_out(obs[0][15:14]),
        .cmp_a_pos_hyst_sel_out(obs[0][13:12]), .cmp_a_neg_hyst_sel_out(obs[0][11:10]),
        .cmp_a_pos_input_sel_out(obs[0][9:6]), .cmp_a_neg_input_sel_out(obs[0][5:2]),
        .cmp_b_enable_out(obs[1][16]), .cmp_b_speed_mode_out(obs[1][15:14]),
        .cmp_b_pos_hyst_sel_out(obs[1][13:12]), .cmp_b_neg_hyst_sel_out(obs[1][11:10]),
        .cmp_b_pos_input_sel_out(obs[1][9:6]), .cmp_b_neg_input_sel_out(obs[1][5:2]),
        .cmp_a_pin_out(obs[0][1]), .cmp_b_pin_out(obs[1][1]),
        .cmp_a_irq_out(obs[0][0]), .cmp_b_irq_out(obs[1][0]));

    // ********
    // Model and helpers
    // ********
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic logic [16:0] exp_obs(input int x);
        return {ctl[x][7], mode[x][1:0], ctl[x][3:0], sel[x][3:0], sel[x][7:4], ctl[x][6],
                (ctl[x][5] & mode[x][5]) | (ctl[x][4] & mode[x][4])};
    endfunction : exp_obs

    function automatic logic [7:0] exp_reg(input int i);
        if (i < 0 || i > 5) return 8'h00;
        return (i % 3 == 0) ? ctl[i/3] : (i % 3 == 1) ? mode[i/3] : sel[i/3];
    endfunction : exp_reg

    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Edges are taken from the gated state, so disabling a high output is a fall.
    task automatic settle();
        logic st;
        repeat (6) @(posedge ref_clk_in);
        for (int x = 0; x < 2; x++) begin
            st = raw[x] & ctl[x][7];
            if (st && !ctl[x][6]) ctl[x][5] = 1'b1;
            if (!st && ctl[x][6]) ctl[x][4] = 1'b1;
            ctl[x][6] = st;
        end
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int i;
        i = int'(a) - 32'h9a;
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_en_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_wr_en_in <= 1'b0;
        if (i >= 0 && i % 3 == 0 && i < 6) ctl[i/3] = (d & 8'hbf) | (ctl[i/3] & 8'h40);
        if (i >= 0 && i % 3 == 1 && i < 6) mode[i/3] = d & 8'h33;
        if (i >= 0 && i % 3 == 2 && i < 6) sel[i/3] = d;
        settle();
    endtask : wr

    // Raw levels stand for pins set up as analog inputs that the crossbar skips.
    task automatic set_raw(input int x, input logic v);
        raw[x] <= v;
        settle();
    endtask : set_raw

    task automatic chk_all();
        cmp(obs[0], exp_obs(0));
        cmp(obs[1], exp_obs(1));
        for (int a = 32'h98; a < 32'ha2; a++) begin
            sfr_addr_in <= 8'(a);
            sfr_rd_en_in <= 1'b1;
            @(posedge ref_clk_in);
            sfr_rd_en_in <= 1'b0;
            @(posedge ref_clk_in);
            cmp(17'(sfr_rdata_out), 17'(exp_reg(a - 32'h9a)));
        end
    endtask : chk_all

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // ********
    // Sequence
    // ********
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        chk_all();
        for (int x = 0; x < 2; x++) begin
            wr(8'(32'h9b + 3 * x), 8'hff);
            wr(8'(32'h9a + 3 * x), 8'hc0);
            set_raw(x, 1'b1);
            chk_all();
            set_raw(x, 1'b0);
            wr(8'(32'h9a + 3 * x), 8'h90);
            chk_all();
            wr(8'(32'h9b + 3 * x), 8'h00);
            set_raw(x, 1'b1);
            wr(8'(32'h9a + 3 * x), 8'h3f);
            chk_all();
        end
        wr(8'h9c, 8'h35);
        wr(8'h9f, 8'h35);
        chk_all();
        // A clearing write that lands with a rising edge must leave the flag set.
        set_raw(1, 1'b0);
        wr(8'h9d, 8'h80);
        raw[1] <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        wr(8'h9d, 8'h80);
        chk_all();
        for (int n = 0; n < 150; n++) begin
            rng = xs(rng);
            if (rng[0]) set_raw(int'(rng[1]), rng[2]);
            else wr(8'h98 + 8'(rng[11:8] % 4'ha), rng[23:16]);
            chk_all();
        end
        final_report();
    end
endmodule : tb_dccr_top
